// File: bench/pjd_jam_detector_properties.sv
`timescale 1ns/10ps

// ****************************************
// Jam detector port checker
// ****************************************
module pjd_jam_detector_properties
  import pjd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic page_top_sensor,
  input wire logic lifter_driver_fault,
  input wire logic door_open,
  input wire logic powersave_exit,
  input wire logic feed_in_progress,
  input wire logic jam_clear,
  input wire logic jam_flag,
  input wire logic [3:0] jam_code,
  input wire logic main_feed_motor,
  input wire logic pickup_retry,
  input wire logic auto_clear,
  input wire logic lift_fault,
  input wire logic lifter_motor_fault
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // A jam always carries a code and leaves the rollers stopped.
  flag_code_a:
  assert property (jam_flag |-> jam_code != JAM_NONE && !main_feed_motor)
    else $error("Jam flag without code or with motor running.");
  no_jam_code_a:
  assert property (!jam_flag |-> jam_code == JAM_NONE)
    else $error("Code shown without jam flag.");
  jam_hold_a:
  assert property (jam_flag && !jam_clear |=> jam_flag && $stable(jam_code))
    else $error("Jam dropped or changed without clear.");
  door_jam_a:
  assert property (door_open && feed_in_progress && !jam_flag |=> jam_flag && jam_code == JAM_DOOR)
    else $error("Door opened in feed without door jam.");
  clear_refused_a:
  assert property (jam_flag && jam_clear && door_open && feed_in_progress |=> jam_flag)
    else $error("Jam cleared while door open in feed.");
  powersave_res_a:
  assert property (powersave_exit && page_top_sensor && !jam_flag && !(door_open && feed_in_progress)
                   |=> jam_flag && jam_code == JAM_RESIDUAL)
    else $error("Paper at power-save exit not flagged.");
  clear_pulse_a:
  assert property (auto_clear |=> !auto_clear)
    else $error("Auto clear longer than one cycle.");
  retry_pulse_a:
  assert property (pickup_retry |-> !jam_flag ##1 !pickup_retry)
    else $error("Retry pulse malformed or during jam.");
  lift_keep_a:
  assert property (lift_fault && !jam_clear |=> lift_fault)
    else $error("Lift fault dropped without clear.");
  lift_motor_a:
  assert property (lift_fault && !jam_flag |-> main_feed_motor)
    else $error("Lift fault stopped the feed motor.");
  driver_fault_a:
  assert property (lifter_driver_fault |=> lifter_motor_fault)
    else $error("Driver fault not reported.");
endmodule : pjd_jam_detector_properties

bind pjd_jam_detector pjd_jam_detector_properties chk (
  .sys_clk(sys_clk), .srst(srst), .page_top_sensor(page_top_sensor),
  .lifter_driver_fault(lifter_driver_fault), .door_open(door_open), .powersave_exit(powersave_exit),
  .feed_in_progress(feed_in_progress), .jam_clear(jam_clear), .jam_flag(jam_flag), .jam_code(jam_code),
  .main_feed_motor(main_feed_motor), .pickup_retry(pickup_retry), .auto_clear(auto_clear),
  .lift_fault(lift_fault), .lifter_motor_fault(lifter_motor_fault)
);

// File: bench/pjd_jam_detector_test.sv
`timescale 1ns/10ps

// ****************************************
// Jam detector testbench
// ****************************************
module pjd_jam_detector_test
  import pjd_pkg::*;
();
  logic sys_clk = 1'b0, srst = 1'b1, res = 1'b1, go = 1'b0, fu = 1'b0, lm = 1'b0, df = 1'b0;
  logic clutch = 1'b0, dup = 1'b0, drep = 1'b0, door = 1'b0, psx = 1'b0, feed = 1'b0, clr = 1'b0, ss = 1'b0;
  logic [1:0] mode = 2'h0, src = SRC_CASSETTE;
  logic [2:0] stg = 3'h0;
  logic [NUM_TMO-1:0][15:0] lim;
  logic [5:0] sens;
  logic sb_go, jam_flag, main_feed_motor, pickup_retry, auto_clear, lift_fault, lifter_motor_fault;
  logic [3:0] jam_code;
  logic pt_q = 1'b0;
  int num_errors = 0, checks_done = 0, cyc = 0, t_top = 0, n_ac = 0, n_rt = 0;
  wire logic pt = sens[1] | res;

  always #50 sys_clk = ~sys_clk;

  // Cycle counter, page-top edge stamp and pulse counters; one-cycle pulses would be missed by polling.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pt_q <= pt;
    if (pt && !pt_q) t_top <= cyc;
    if (auto_clear === 1'b1) n_ac <= n_ac + 1;
    if (pickup_retry === 1'b1) n_rt <= n_rt + 1;
  end

  pjd_path_model path (
    .sys_clk(sys_clk), .go(go), .mode(mode), .stage(stg), .face_up(fu), .sens(sens), .sb_go(sb_go)
  );

  pjd_jam_detector #(.TMO_WIDTH(16), .OTHER_TRIES(4'h3)) dut (
    .sys_clk(sys_clk), .srst(srst), .prefeed_sensor(sens[0]), .page_top_sensor(pt),
    .width_sensor_one(sens[2]), .width_sensor_two(sens[2]), .fuser_out_sensor(sens[3]),
    .switchback_jam_sensor(sens[4]), .delivery_sensor(sens[5]), .duplex_repick_sensor(drep),
    .stack_surface_sensor_one(ss), .cassette_lifter_motor(lm), .lifter_driver_fault(df),
    .pickup_source(src), .media_feed_clutch(clutch), .duplex_reverse_start(dup),
    .switchback_start(sb_go), .face_up(fu), .door_open(door), .powersave_exit(psx),
    .feed_in_progress(feed), .jam_clear(clr), .tmo_limit(lim), .jam_flag(jam_flag),
    .jam_code(jam_code), .main_feed_motor(main_feed_motor), .pickup_retry(pickup_retry),
    .auto_clear(auto_clear), .lift_fault(lift_fault), .lifter_motor_fault(lifter_motor_fault)
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic wait_jam(int n);
    for (int i = 0; i < n && jam_flag !== 1'b1; i++) @(negedge sys_clk);
  endtask : wait_jam

  task automatic do_reset();
    @(posedge sys_clk);
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(2);
  endtask : do_reset

  task automatic pulse_clear();
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : pulse_clear

  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Scenarios
  // ****************************************
  // Paper left on the page-top sensor at power-on.
  task automatic t_power();
    wait_jam(10);
    check("power-on code", 8'(jam_code), 8'(JAM_RESIDUAL));
    check("motor off", 8'(main_feed_motor), 8'h0);
    tick(1);
    res <= 1'b0;
    tick(2);
    pulse_clear();
    tick(2);
    check("auto clear", 8'(n_ac), 8'h1);
    check("cleared", 8'({jam_flag, main_feed_motor}), 8'h1);
    do_reset();
  endtask : t_power

  // A clean sheet must pass every checkpoint without a jam.
  task automatic t_sheet(logic f);
    @(posedge sys_clk);
    fu <= f;
    mode <= 2'h0;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    tick(80);
    check("clean sheet", 8'({jam_flag, jam_code}), 8'h0);
  endtask : t_sheet

  // A sheet lost or stuck at one sensor gives the code of that checkpoint.
  task automatic t_stall(logic [1:0] m, logic [2:0] s, logic f, logic [3:0] code);
    @(posedge sys_clk);
    fu <= f;
    mode <= m;
    stg <= s;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wait_jam(80);
    check("stall code", 8'(jam_code), 8'(code));
    if (code == JAM_FUSER_DELAY) check("delay", 8'(cyc - t_top), 8'(lim[TMO_FUSER_LEAD] + 3));
    tick(70);
    do_reset();
  endtask : t_stall

  // Attempts with no page-top edge: a retry after each but the last, which jams.
  task automatic t_pick(logic [1:0] s);
    int base, n;
    base = n_rt;
    n = (s == SRC_MANUAL) ? MANUAL_TRIES : DEFAULT_TRIES;
    src <= s;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      mode <= 2'h1;
      stg <= 3'h1;
      go <= s != SRC_ACCESSORY;
      clutch <= s == SRC_ACCESSORY;
      @(posedge sys_clk);
      go <= 1'b0;
      tick(40);
      clutch <= 1'b0;
      tick(30);
    end
    check("retries", 8'(n_rt - base), 8'(n - 1));
    check("pick code", 8'(jam_code), 8'(JAM_PICKUP));
    src <= SRC_CASSETTE;
    do_reset();
  endtask : t_pick

  // Re-pickup in time is quiet, a missing re-pickup is a jam.
  task automatic t_dup();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      dup <= 1'b1;
      @(posedge sys_clk);
      dup <= 1'b0;
      tick(5);
      drep <= i == 0;
      tick(30);
      drep <= 1'b0;
    end
    check("duplex code", 8'(jam_code), 8'(JAM_DUPLEX));
    do_reset();
  endtask : t_dup

  // Door jam, refused clear, then residual at door closure and at power-save exit.
  task automatic t_door();
    @(posedge sys_clk);
    feed <= 1'b1;
    door <= 1'b1;
    wait_jam(5);
    check("door code", 8'(jam_code), 8'(JAM_DOOR));
    pulse_clear();
    tick(1);
    check("refused", 8'(jam_flag), 8'h1);
    feed <= 1'b0;
    pulse_clear();
    tick(1);
    check("door clear", 8'(jam_flag), 8'h0);
    res <= 1'b1;
    door <= 1'b0;
    wait_jam(5);
    tick(2);
    check("closure", 8'({n_ac[3:0], jam_code}), 8'h2c);
    pulse_clear();
    psx <= 1'b1;
    @(posedge sys_clk);
    psx <= 1'b0;
    wait_jam(5);
    tick(2);
    check("power-save", 8'({n_ac[3:0], jam_code}), 8'h2c);
    res <= 1'b0;
    do_reset();
  endtask : t_door

  // Surface found in time is quiet; a lift that never finds it faults, then the driver reports one.
  task automatic t_lift();
    @(posedge sys_clk);
    lm <= 1'b1;
    tick(5);
    ss <= 1'b1;
    tick(25);
    check("lift found", 8'(lift_fault), 8'h0);
    lm <= 1'b0;
    ss <= 1'b0;
    tick(1);
    lm <= 1'b1;
    tick(25);
    check("lift", 8'({lift_fault, main_feed_motor}), 8'h3);
    df <= 1'b1;
    @(posedge sys_clk);
    df <= 1'b0;
    tick(1);
    check("driver", 8'(lifter_motor_fault), 8'h1);
    pulse_clear();
    tick(1);
    check("faults clear", 8'({lift_fault, lifter_motor_fault}), 8'h0);
  endtask : t_lift

  // Hang guard, far beyond the few thousand cycles the scenarios need.
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end

  // Main sequence; the wrap window is short so a normal sheet stays quiet.
  initial begin
    for (int i = 0; i < NUM_TMO; i++) lim[i] = (i == TMO_WRAP) ? 16'h3 : 16'h10;
    tick(3);
    srst <= 1'b0;
    t_power();
    t_sheet(1'b0);
    t_sheet(1'b1);
    t_stall(2'h1, 3'h3, 1'b1, JAM_FUSER_DELAY);
    t_stall(2'h1, 3'h4, 1'b1, JAM_OUT2_DELAY);
    t_stall(2'h1, 3'h5, 1'b0, JAM_OUT3_DELAY);
    t_stall(2'h1, 3'h5, 1'b1, JAM_OUT3_DELAY);
    t_stall(2'h2, 3'h1, 1'b1, JAM_FEED_STAY_TOP);
    t_stall(2'h2, 3'h2, 1'b1, JAM_FEED_STAY_WIDTH);
    t_stall(2'h2, 3'h3, 1'b1, JAM_FUSER_STAY);
    t_stall(2'h2, 3'h4, 1'b1, JAM_OUT2_STAY);
    t_stall(2'h2, 3'h5, 1'b1, JAM_OUT3_STAY);
    t_stall(2'h3, 3'h0, 1'b1, JAM_FUSER_WRAP);
    t_pick(SRC_CASSETTE);
    t_pick(SRC_ACCESSORY);
    t_pick(SRC_MANUAL);
    t_dup();
    t_door();
    t_lift();
    summarize();
  end
endmodule : pjd_jam_detector_test

// File: bench/pjd_path_model.sv
`timescale 1ns/10ps

// ****************************************
// Paper path partner model
// ****************************************
module pjd_path_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [2:0] stage,
  input wire logic face_up,
  output logic [5:0] sens,
  output logic sb_go
);
  int t = 99;

  // Sensor k sees the sheet from 4k to 4k+6; mode 1 loses it, 2 sticks it, 3 drops it at the fuser.
  function automatic logic at(int k);
    logic n;
    n = t >= 4 * k && t < 4 * k + 6;
    if (mode == 2'h1 && k >= stage) n = 1'b0;
    if (mode == 2'h2 && k == stage && t >= 4 * k) n = t < 64;
    if (mode == 2'h3 && k == 3 && t >= 14) n = 1'b0;
    return n;
  endfunction : at

  // Sensors start clear so the detector never sees an unknown level.
  initial begin
    sens = 6'h00;
    sb_go = 1'b0;
  end

  // The sheet advances one step a cycle; the switchback starts only if the sheet got that far.
  always @(posedge sys_clk) begin
    t <= go ? 0 : (t < 99 ? t + 1 : t);
    for (int k = 0; k < 6; k++) begin
      sens[k] <= at(k);
    end
    sb_go <= t == 16 && !face_up && !(mode == 2'h1 && stage <= 3'h4);
  end
endmodule : pjd_path_model

// File: inc/pjd_pkg.sv
// Functional notes
// (RULE1) Cassette pickup: page-top leading edge late after pre-feed leading edge flags pickup jam.
// (RULE2) Accessory pickup: page-top leading edge late after feed clutch on flags pickup jam.
// (RULE3) Pickup is retried per source before the jam; manual tray gets four attempts.
// (RULE4) Page-top trailing edge late after its leading edge flags feed stay jam.
// (RULE5) Both width sensors still covered too long after page-top trailing edge: feed stay; flagged if either one is still covered.
// (RULE6) Fuser output leading edge late after page-top leading edge flags fuser delay.
// (RULE7) Fuser output trailing edge late after page-top trailing edge flags fuser stay.
// (RULE8) Fuser output losing paper inside window after its leading edge flags fuser wrap.
// (RULE9) Switchback jam sensor leading edge late after fuser output leading edge: delay two.
// (RULE10) Switchback jam sensor trailing edge late after fuser output trailing edge: stay two.
// (RULE11) Duplex re-pickup sensor leading edge late after duplex reverse start flags jam.
// (RULE12) Face-down: delivery edges late after switchback start flag delay or stay three.
// (RULE13) Face-up: delivery edges late after fuser output leading edge flag delay or stay three.
// (RULE14) Paper at power-on, door closure or power-save exit flags residual jam.
// (RULE15) Door opened during a feed operation flags door open jam.
// (RULE16) Leftover paper at power-on or door closure starts automatic clearing.
// (RULE17) Stack surface sensor one late after lifter motor start reports lift-up fault.
// (RULE18) Lifter driver status reporting a fault flags lifter motor failure.
// (RULE19) Any jam switches all motors off and raises the jam indication; only main_feed_motor is switched off.
// (RULE20) Each checkpoint timeout is its own programmable count; each jam a distinct code.
package pjd_pkg;

  // ****************************************
  // Checkpoint timer indices
  // ****************************************
  localparam int NUM_TMO = 12;
  localparam int TMO_PICK = 0;
  localparam int TMO_TOP_TRAIL = 1;
  localparam int TMO_WIDTH_TRAIL = 2;
  localparam int TMO_FUSER_LEAD = 3;
  localparam int TMO_FUSER_TRAIL = 4;
  localparam int TMO_WRAP = 5;
  localparam int TMO_SB_LEAD = 6;
  localparam int TMO_SB_TRAIL = 7;
  localparam int TMO_DUPLEX = 8;
  localparam int TMO_DELIV_LEAD = 9;
  localparam int TMO_DELIV_TRAIL = 10;
  localparam int TMO_LIFT = 11;

  // ****************************************
  // Jam codes reported to the formatter
  // ****************************************
  localparam logic [3:0] JAM_NONE = 4'h0;
  localparam logic [3:0] JAM_PICKUP = 4'h1;
  localparam logic [3:0] JAM_FEED_STAY_TOP = 4'h2;
  localparam logic [3:0] JAM_FEED_STAY_WIDTH = 4'h3;
  localparam logic [3:0] JAM_FUSER_DELAY = 4'h4;
  localparam logic [3:0] JAM_FUSER_STAY = 4'h5;
  localparam logic [3:0] JAM_FUSER_WRAP = 4'h6;
  localparam logic [3:0] JAM_OUT2_DELAY = 4'h7;
  localparam logic [3:0] JAM_OUT2_STAY = 4'h8;
  localparam logic [3:0] JAM_DUPLEX = 4'h9;
  localparam logic [3:0] JAM_OUT3_DELAY = 4'ha;
  localparam logic [3:0] JAM_OUT3_STAY = 4'hb;
  localparam logic [3:0] JAM_RESIDUAL = 4'hc;
  localparam logic [3:0] JAM_DOOR = 4'hd;

  // ****************************************
  // Pickup sources and attempt counts
  // ****************************************
  localparam logic [1:0] SRC_MANUAL = 2'h0;
  localparam logic [1:0] SRC_CASSETTE = 2'h1;
  localparam logic [1:0] SRC_ACCESSORY = 2'h2;
  localparam logic [3:0] MANUAL_TRIES = 4'h4;
  localparam logic [3:0] DEFAULT_TRIES = 4'h3;
  localparam int DEFAULT_TMO_WIDTH = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_TRIES = 4'h0;
  localparam logic RST_POR_PENDING = 1'b1;

  typedef enum logic [0:0] {ST_RUN, ST_JAM} pjd_state_e;

endpackage : pjd_pkg

// File: rtl/pjd_jam_detector.sv
`timescale 1ns/10ps

// ****************************************
// Checkpoint timer
// ****************************************
module pjd_timer #(
  parameter int TW = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic stop,
  input wire logic abort,
  input wire logic [TW-1:0] limit,
  output logic running,
  output logic expired,
  output logic stopped
);
  logic [TW-1:0] count;

  // A start wins over a stop in the same cycle so a new page is never missed.
  always_ff @(posedge sys_clk) begin
    if (srst || abort) begin
      running <= 1'b0;
      count <= '0;
      expired <= 1'b0;
      stopped <= 1'b0;
    end else begin
      expired <= 1'b0;
      stopped <= 1'b0;
      if (start) begin
        running <= 1'b1;
        count <= '0;
      end else if (running && stop) begin
        running <= 1'b0;
        stopped <= 1'b1;
      end else if (running && (count >= limit)) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else if (running) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : pjd_timer

// ****************************************
// Paper path jam detector
// ****************************************
module pjd_jam_detector
  import pjd_pkg::*;
#(
  parameter int TMO_WIDTH = DEFAULT_TMO_WIDTH,
  parameter logic [3:0] OTHER_TRIES = DEFAULT_TRIES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic prefeed_sensor,
  input wire logic page_top_sensor,
  input wire logic width_sensor_one,
  input wire logic width_sensor_two,
  input wire logic fuser_out_sensor,
  input wire logic switchback_jam_sensor,
  input wire logic delivery_sensor,
  input wire logic duplex_repick_sensor,
  input wire logic stack_surface_sensor_one,
  input wire logic cassette_lifter_motor,
  input wire logic lifter_driver_fault,
  input wire logic [1:0] pickup_source,
  input wire logic media_feed_clutch,
  input wire logic duplex_reverse_start,
  input wire logic switchback_start,
  input wire logic face_up,
  input wire logic door_open,
  input wire logic powersave_exit,
  input wire logic feed_in_progress,
  input wire logic jam_clear,
  input wire logic [NUM_TMO-1:0][TMO_WIDTH-1:0] tmo_limit,
  output logic jam_flag,
  output logic [3:0] jam_code,
  output logic main_feed_motor,
  output logic pickup_retry,
  output logic auto_clear,
  output logic lift_fault,
  output logic lifter_motor_fault
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TMO_WIDTH < 2 || TMO_WIDTH > 32) begin : g_bad_width
    $error("TMO_WIDTH must lie between 2 and 32");
  end
  if (OTHER_TRIES == 4'h0) begin : g_bad_tries
    $error("OTHER_TRIES must be at least one");
  end

  // ****************************************
  // Edge detection
  // ****************************************
  logic prefeed_d, top_d, fuser_d, sb_d, deliv_d, duplex_d, clutch_d, lifter_d, door_d;
  logic top_rise, top_fall, fuser_rise, fuser_fall, width_any;
  pjd_state_e state;

  // All sensor inputs are synchronous, so one stage of history gives clean edges.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prefeed_d <= 1'b0;
      top_d <= 1'b0;
      fuser_d <= 1'b0;
      sb_d <= 1'b0;
      deliv_d <= 1'b0;
      duplex_d <= 1'b0;
      clutch_d <= 1'b0;
      lifter_d <= 1'b0;
      door_d <= 1'b0;
    end else begin
      prefeed_d <= prefeed_sensor;
      top_d <= page_top_sensor;
      fuser_d <= fuser_out_sensor;
      sb_d <= switchback_jam_sensor;
      deliv_d <= delivery_sensor;
      duplex_d <= duplex_repick_sensor;
      clutch_d <= media_feed_clutch;
      lifter_d <= cassette_lifter_motor;
      door_d <= door_open;
    end
  end

  assign top_rise = page_top_sensor & ~top_d;
  assign top_fall = ~page_top_sensor & top_d;
  assign fuser_rise = fuser_out_sensor & ~fuser_d;
  assign fuser_fall = ~fuser_out_sensor & fuser_d;
  assign width_any = width_sensor_one | width_sensor_two;

  // ****************************************
  // Checkpoint timers
  // ****************************************
  logic [NUM_TMO-1:0] t_start, t_stop, t_exp, t_stopped;
  logic abort_all;
  logic deliv_start;

  assign abort_all = (state == ST_JAM);

  always_comb begin
    t_start = '0;
    t_stop = '0;
    // (RULE1) Cassette pickup start point.
    // (RULE2) Accessory pickup start point.
    if (pickup_source == SRC_ACCESSORY) begin
      t_start[TMO_PICK] = media_feed_clutch & ~clutch_d;
    end else begin
      t_start[TMO_PICK] = prefeed_sensor & ~prefeed_d;
    end
    t_stop[TMO_PICK] = top_rise;
    // (RULE4) Page-top trailing edge.
    t_start[TMO_TOP_TRAIL] = top_rise;
    t_stop[TMO_TOP_TRAIL] = top_fall;
    // (RULE5) Width sensors clear.
    t_start[TMO_WIDTH_TRAIL] = top_fall;
    t_stop[TMO_WIDTH_TRAIL] = ~width_any;
    // (RULE6) Fuser output leading edge.
    t_start[TMO_FUSER_LEAD] = top_rise;
    t_stop[TMO_FUSER_LEAD] = fuser_rise;
    // (RULE7) Fuser output trailing edge.
    t_start[TMO_FUSER_TRAIL] = top_fall;
    t_stop[TMO_FUSER_TRAIL] = fuser_fall;
    // (RULE8) Wrap watch window.
    t_start[TMO_WRAP] = fuser_rise;
    t_stop[TMO_WRAP] = ~fuser_out_sensor;
    // (RULE9) Switchback jam sensor leading edge.
    t_start[TMO_SB_LEAD] = fuser_rise;
    t_stop[TMO_SB_LEAD] = switchback_jam_sensor & ~sb_d;
    // (RULE10) Switchback jam sensor trailing edge.
    t_start[TMO_SB_TRAIL] = fuser_fall;
    t_stop[TMO_SB_TRAIL] = ~switchback_jam_sensor & sb_d;
    // (RULE11) Duplex re-pickup leading edge.
    t_start[TMO_DUPLEX] = duplex_reverse_start;
    t_stop[TMO_DUPLEX] = duplex_repick_sensor & ~duplex_d;
    // (RULE12) Face-down delivery is timed from the switchback start.
    // (RULE13) Face-up delivery is timed from the fuser output leading edge.
    t_start[TMO_DELIV_LEAD] = deliv_start;
    t_stop[TMO_DELIV_LEAD] = delivery_sensor & ~deliv_d;
    t_start[TMO_DELIV_TRAIL] = deliv_start;
    t_stop[TMO_DELIV_TRAIL] = ~delivery_sensor & deliv_d;
    // (RULE17) Lifter start to stack surface found.
    t_start[TMO_LIFT] = cassette_lifter_motor & ~lifter_d;
    t_stop[TMO_LIFT] = stack_surface_sensor_one;
  end

  assign deliv_start = face_up ? fuser_rise : switchback_start;

  // (RULE20) One independent timer and limit per checkpoint.
  for (genvar i = 0; i < NUM_TMO; i++) begin : g_tmo
    pjd_timer #(
      .TW(TMO_WIDTH)
    ) u_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .start(t_start[i]),
      .stop(t_stop[i]),
      .abort(abort_all && (i != TMO_LIFT)),
      .limit(tmo_limit[i]),
      .running(),
      .expired(t_exp[i]),
      .stopped(t_stopped[i])
    );
  end

  // ****************************************
  // Pickup attempts
  // ****************************************
  logic [3:0] tries;
  logic [3:0] max_tries;
  logic pick_fail;

  // The manual tray gets a fixed count; every other source uses the parameter.
  assign max_tries = (pickup_source == SRC_MANUAL) ? MANUAL_TRIES : OTHER_TRIES;
  assign pick_fail = t_exp[TMO_PICK] && ((tries + 4'h1) >= max_tries);

  // (RULE3) Count failed attempts and ask for a retry until the limit.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tries <= RST_TRIES;
      pickup_retry <= 1'b0;
    end else begin
      pickup_retry <= 1'b0;
      if (top_rise || state == ST_JAM) begin
        tries <= RST_TRIES;
      end else if (t_exp[TMO_PICK]) begin
        if (pick_fail) begin
          tries <= RST_TRIES;
        end else begin
          tries <= tries + 4'h1;
          pickup_retry <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Residual paper check triggers
  // ****************************************
  logic por_pending, door_close, residual, check_now, clear_trigger;

  assign door_close = door_d & ~door_open;
  assign residual = page_top_sensor | width_any | fuser_out_sensor;
  assign check_now = por_pending | door_close | powersave_exit;
  assign clear_trigger = por_pending | door_close;

  // The power-on check runs once, in the first cycle after reset is released.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      por_pending <= RST_POR_PENDING;
    end else begin
      por_pending <= 1'b0;
    end
  end

  // (RULE16) Automatic clearing pulse.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auto_clear <= 1'b0;
    end else begin
      auto_clear <= clear_trigger & residual;
    end
  end

  // ****************************************
  // Jam classification
  // ****************************************
  logic [3:0] next_code;

  // Priority only matters when two checkpoints fail in one cycle; the earlier
  // stage of the path is reported because it is the likely root cause.
  always_comb begin
    next_code = JAM_NONE;
    // (RULE15) Door open during feed.
    if (door_open && feed_in_progress) begin
      next_code = JAM_DOOR;
    // (RULE14) Residual paper.
    end else if (check_now && residual) begin
      next_code = JAM_RESIDUAL;
    // (RULE1) Pickup jam after last attempt.
    end else if (pick_fail) begin
      next_code = JAM_PICKUP;
    // (RULE4) Page-top stay.
    end else if (t_exp[TMO_TOP_TRAIL]) begin
      next_code = JAM_FEED_STAY_TOP;
    // (RULE5) Width stay.
    end else if (t_exp[TMO_WIDTH_TRAIL]) begin
      next_code = JAM_FEED_STAY_WIDTH;
    // (RULE6) Fuser delay.
    end else if (t_exp[TMO_FUSER_LEAD]) begin
      next_code = JAM_FUSER_DELAY;
    // (RULE7) Fuser stay.
    end else if (t_exp[TMO_FUSER_TRAIL]) begin
      next_code = JAM_FUSER_STAY;
    // (RULE8) Paper lost early means wrap.
    end else if (t_stopped[TMO_WRAP]) begin
      next_code = JAM_FUSER_WRAP;
    // (RULE9) Second-stage delay.
    end else if (t_exp[TMO_SB_LEAD]) begin
      next_code = JAM_OUT2_DELAY;
    // (RULE10) Second-stage stay.
    end else if (t_exp[TMO_SB_TRAIL]) begin
      next_code = JAM_OUT2_STAY;
    // (RULE11) Duplex re-pickup.
    end else if (t_exp[TMO_DUPLEX]) begin
      next_code = JAM_DUPLEX;
    // (RULE12) Third-stage delay.
    end else if (t_exp[TMO_DELIV_LEAD]) begin
      next_code = JAM_OUT3_DELAY;
    // (RULE13) Third-stage stay.
    end else if (t_exp[TMO_DELIV_TRAIL]) begin
      next_code = JAM_OUT3_STAY;
    end
  end

  // ****************************************
  // Jam state and transport control
  // ****************************************
  // (RULE19) A jam stops the main feed motor and holds the indication until cleared.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_RUN;
      jam_flag <= 1'b0;
      jam_code <= JAM_NONE;
      main_feed_motor <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          main_feed_motor <= 1'b1;
          if (next_code != JAM_NONE) begin
            state <= ST_JAM;
            jam_flag <= 1'b1;
            jam_code <= next_code;
            main_feed_motor <= 1'b0;
          end
        end
        ST_JAM: begin
          main_feed_motor <= 1'b0;
          // A clear is refused while the door is still open during feed.
          if (jam_clear && !(door_open && feed_in_progress)) begin
            state <= ST_RUN;
            jam_flag <= 1'b0;
            jam_code <= JAM_NONE;
          end
        end
        default: begin
          state <= ST_JAM;
          jam_flag <= 1'b1;
          main_feed_motor <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Optional feeder faults
  // ****************************************
  // A fault that arrives in the clearing cycle wins, so no event is dropped.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lift_fault <= 1'b0;
      lifter_motor_fault <= 1'b0;
    end else begin
      // (RULE17) Lift-up fault.
      if (t_exp[TMO_LIFT]) begin
        lift_fault <= 1'b1;
      end else if (jam_clear) begin
        lift_fault <= 1'b0;
      end
      // (RULE18) Lifter driver fault.
      if (lifter_driver_fault) begin
        lifter_motor_fault <= 1'b1;
      end else if (jam_clear) begin
        lifter_motor_fault <= 1'b0;
      end
    end
  end

endmodule : pjd_jam_detector
